/* File: src/axis_io_pkg.sv */
// Shared constants and types for the per-axis signal handling block
// Summary of operation
// - General outputs follow output data register bits
// - General outputs low from reset until written
// - Output data write needs no axis selection
// - Enabled in-position holds driving flag until active
// - Enabled active alarm sets alarm flag
// - Plus limit stops plus-direction pulse output
// - Enabled active plus limit sets plus flag
// - Minus limit stops minus-direction pulse output
// - Limit stop kind and level are configurable
// - Enabled active minus limit sets minus flag
// - Stop inputs stop axis, selectable enable, level
// - Home search maps stop inputs 0,1,2
// - Input levels readable through two status words
// - Fixed external start on falling edges
// - Continuous external start while input low
// - Pulse generator mode maps starts to A/B
// - Emergency low stops every axis at once
// - Emergency sets emergency flag on every axis
// - Emergency is active low, pulse over two clocks
// - Drive output held high until in-position active
package axis_io_pkg;
  localparam int num_axes = 4;
  localparam int stop_per_axis = 4;
  localparam logic [15:0] gen_out_rst = 16'h0000;
  // Pin to output latency: two sync stages plus output flop
  localparam logic [1:0] field_lat = 2'h3;
  localparam int min_pulse_clk = 2;
  // Field vector layout after synchronisation
  localparam int fld_emg = 0;
  localparam int fld_stop = 1;
  localparam int fld_inpos = 17;
  localparam int fld_alarm = 21;
  localparam int fld_lmtp = 25;
  localparam int fld_lmtm = 29;
  localparam int fld_expp = 33;
  localparam int fld_expm = 37;
  localparam int fld_w = 41;
  // Idle pin levels loaded at reset: all field inputs high
  localparam logic [40:0] fld_rst = 41'h1ffffffffff;
  typedef enum logic [3:0] {
    ext_off = 4'h1,
    ext_fixed = 4'h2,
    ext_cont = 4'h4,
    ext_mpg = 4'h8
  } ext_mode_t;
endpackage : axis_io_pkg

/* File: src/axis_io_signal_handling.sv */
// Per-axis field input and general output handling for four axes
`timescale 1ns/1ps
module axis_io_signal_handling
  import axis_io_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic [15:0] i_out_data,
  input wire logic i_out_wr,
  input wire logic [3:0] i_inpos_en,
  input wire logic [3:0] i_inpos_lvl,
  input wire logic [3:0] i_alarm_en,
  input wire logic [3:0] i_alarm_lvl,
  input wire logic [3:0] i_lmt_en,
  input wire logic [3:0] i_lmt_lvl,
  input wire logic [3:0] i_lmt_sudden,
  input wire logic [15:0] i_stop_en,
  input wire logic [15:0] i_stop_lvl,
  input wire logic [3:0] i_stop_sudden,
  input wire logic [15:0] i_ext_mode,
  input wire logic [3:0] i_pulse_busy,
  input wire logic [3:0] i_pulse_dir,
  input wire logic [3:0] i_home_search,
  input wire logic [3:0] i_in_position,
  input wire logic [3:0] i_servo_alarm,
  input wire logic [3:0] i_plus_limit,
  input wire logic [3:0] i_minus_limit,
  input wire logic [15:0] i_stop_inputs,
  input wire logic [3:0] i_ext_plus_start,
  input wire logic [3:0] i_ext_minus_start,
  input wire logic i_emergency_stop_n,
  output logic [15:0] o_general_out,
  output logic [3:0] o_axis_driving_flag,
  output logic [3:0] o_drive_active_out,
  output logic [3:0] o_alarm_flag,
  output logic [3:0] o_hw_plus_limit_flag,
  output logic [3:0] o_hw_minus_limit_flag,
  output logic [3:0] o_emergency_flag,
  output logic [3:0] o_decel_stop,
  output logic [3:0] o_sudden_stop,
  output logic o_emergency_halt,
  output logic [15:0] o_input_status_a,
  output logic [15:0] o_input_status_b,
  output logic [3:0] o_start_plus,
  output logic [3:0] o_start_minus,
  output logic [3:0] o_run_plus,
  output logic [3:0] o_run_minus,
  output logic [3:0] o_mpg_a,
  output logic [3:0] o_mpg_b,
  output logic [3:0] o_home_near,
  output logic [3:0] o_home_signal,
  output logic [3:0] o_home_zphase
);

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);

  logic [fld_w-1:0] field;
  logic [fld_w-1:0] meta_q;
  logic [fld_w-1:0] sync_q;
  logic [fld_w-1:0] prev_q;
  logic [1:0] up_q;
  logic emg_act;
  logic [15:0] s_stop;
  logic [15:0] stop_act;
  logic [3:0] s_inpos;
  logic [3:0] s_alarm;
  logic [3:0] s_lmtp;
  logic [3:0] s_lmtm;
  logic [3:0] s_expp;
  logic [3:0] s_expm;
  logic [3:0] p_expp;
  logic [3:0] p_expm;
  logic [3:0] inpos_act;
  logic [3:0] alarm_act;
  logic [3:0] lmtp_act;
  logic [3:0] lmtm_act;
  logic [3:0] lim_stop;
  logic [3:0] in_stop;
  logic [3:0] drv_d;
  logic [3:0] dec_d;
  logic [3:0] sud_d;
  logic [3:0] stp_d;
  logic [3:0] stm_d;
  logic [3:0] rnp_d;
  logic [3:0] rnm_d;
  logic [3:0] mpa_d;
  logic [3:0] mpb_d;
  logic [15:0] stat_b_d;

  assign field = {i_ext_minus_start, i_ext_plus_start, i_minus_limit, i_plus_limit,
                  i_servo_alarm, i_in_position, i_stop_inputs, i_emergency_stop_n};

  // Two-stage synchroniser, then one stage for edge detection
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      meta_q <= fld_rst;
      sync_q <= fld_rst;
      prev_q <= fld_rst;
    end else begin
      meta_q <= field;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // Counts sync latency after reset, read by checks only
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      up_q <= 2'h0;
    end else if (up_q != field_lat) begin
      up_q <= up_q + 2'h1;
    end
  end

  assign emg_act = ~sync_q[fld_emg];
  assign s_stop = sync_q[fld_stop+:16];
  assign s_inpos = sync_q[fld_inpos+:4];
  assign s_alarm = sync_q[fld_alarm+:4];
  assign s_lmtp = sync_q[fld_lmtp+:4];
  assign s_lmtm = sync_q[fld_lmtm+:4];
  assign s_expp = sync_q[fld_expp+:4];
  assign s_expm = sync_q[fld_expm+:4];
  assign p_expp = prev_q[fld_expp+:4];
  assign p_expm = prev_q[fld_expm+:4];

  // Level bit set means active high
  assign stop_act = i_stop_en & ~(s_stop ^ i_stop_lvl);
  assign inpos_act = ~(s_inpos ^ i_inpos_lvl);
  assign alarm_act = i_alarm_en & ~(s_alarm ^ i_alarm_lvl);
  assign lmtp_act = ~(s_lmtp ^ i_lmt_lvl);
  assign lmtm_act = ~(s_lmtm ^ i_lmt_lvl);

  genvar a;
  generate
    for (a = 0; a < num_axes; a++) begin : g_axis
      ext_mode_t mode;
      logic stop_any;

      assign mode = ext_mode_t'(i_ext_mode[4*a+:4]);
      // Limits stop only pulses heading into them
      assign lim_stop[a] = i_pulse_busy[a] &
                           ((i_pulse_dir[a] & lmtp_act[a]) |
                            (~i_pulse_dir[a] & lmtm_act[a]));
      // Home search owns the stop inputs as sensors
      assign in_stop[a] = ~i_home_search[a] & (|stop_act[4*a+:4]);
      assign stop_any = lim_stop[a] | in_stop[a];
      assign dec_d[a] = ~emg_act &
                        ((lim_stop[a] & ~i_lmt_sudden[a]) | (in_stop[a] & ~i_stop_sudden[a]));
      assign sud_d[a] = emg_act |
                        (stop_any &
                         ((lim_stop[a] & i_lmt_sudden[a]) | (in_stop[a] & i_stop_sudden[a])));
      // Holds past pulse end while waiting for in-position
      assign drv_d[a] = i_pulse_busy[a] |
                        (o_axis_driving_flag[a] & i_inpos_en[a] & ~inpos_act[a]);
      assign stp_d[a] = (mode == ext_fixed) & ~emg_act & p_expp[a] & ~s_expp[a];
      assign stm_d[a] = (mode == ext_fixed) & ~emg_act & p_expm[a] & ~s_expm[a];
      assign rnp_d[a] = (mode == ext_cont) & ~emg_act & ~s_expp[a];
      assign rnm_d[a] = (mode == ext_cont) & ~emg_act & ~s_expm[a];
      assign mpa_d[a] = (mode == ext_mpg) & s_expp[a];
      assign mpb_d[a] = (mode == ext_mpg) & s_expm[a];
      assign stat_b_d[4*a+:4] = {s_alarm[a], s_inpos[a], s_lmtm[a], s_lmtp[a]};

      sequence s_drive_end;
        i_pulse_busy[a] ##1 (!i_pulse_busy[a] && i_inpos_en[a] && !inpos_act[a]);
      endsequence
      sequence s_lim_plus;
        i_pulse_busy[a] && i_pulse_dir[a] && lmtp_act[a] && !emg_act && !in_stop[a];
      endsequence
      sequence s_fall_minus;
        mode == ext_fixed && !emg_act && $fell(s_expm[a]);
      endsequence

      chk_inpos_hold: assert property (s_drive_end |=> o_axis_driving_flag[a])
        else $error("driving flag dropped before in-position");
      chk_inpos_release: assert property (
        (!i_pulse_busy[a] && inpos_act[a]) |=> (!o_axis_driving_flag[a] && !o_drive_active_out[a]))
        else $error("drive output not released on in-position");
      chk_alarm_pin: assert property (
        (up_q == field_lat && $past(i_alarm_en[a]) && $stable(i_alarm_lvl[a]))
        |-> (o_alarm_flag[a] == ($past(i_servo_alarm[a], 3) == $past(i_alarm_lvl[a]))))
        else $error("alarm flag does not follow alarm pin");
      chk_plus_stop: assert property (
        s_lim_plus |=> ($past(i_lmt_sudden[a]) ? (o_sudden_stop[a] && !o_decel_stop[a])
                                               : (o_decel_stop[a] && !o_sudden_stop[a])))
        else $error("plus limit did not stop plus drive");
      chk_minus_stop: assert property (
        (i_pulse_busy[a] && !i_pulse_dir[a] && lmtm_act[a]) |=> (o_decel_stop[a] || o_sudden_stop[a]))
        else $error("minus limit did not stop minus drive");
      chk_limit_flags: assert property (
        ##1 (o_hw_plus_limit_flag[a] == $past(i_lmt_en[a] && lmtp_act[a]))
            && (o_hw_minus_limit_flag[a] == $past(i_lmt_en[a] && lmtm_act[a])))
        else $error("limit flags wrong");
      chk_stop_input: assert property (
        (!i_home_search[a] && (|stop_act[4*a+:4]) && i_stop_sudden[a] && !lim_stop[a])
        |=> o_sudden_stop[a] && !o_decel_stop[a])
        else $error("stop input did not stop axis");
      chk_fixed_start: assert property (
        (mode == ext_fixed && !emg_act && $fell(s_expp[a])) |=> o_start_plus[a] ##1 !o_start_plus[a])
        else $error("fixed start pulse wrong");
      chk_cont_run: assert property (
        (mode == ext_cont && !emg_act) |=> (o_run_minus[a] == !$past(s_expm[a])))
        else $error("continuous run not following start input");
      chk_mpg_map: assert property (
        (mode == ext_mpg) |=> (o_mpg_a[a] == $past(s_expp[a])) && !o_run_plus[a])
        else $error("pulse generator phase mapping wrong");
      chk_home_map: assert property (
        (i_home_search[a] && !lim_stop[a])
        |=> (o_home_signal[a] == $past(stop_act[4*a+1])) && !o_decel_stop[a])
        else $error("home sensor mapping wrong");
      chk_home_taps: assert property (
        i_home_search[a] |=> (o_home_near[a] == $past(stop_act[4*a]))
                             && (o_home_zphase[a] == $past(stop_act[4*a+2])))
        else $error("near-home or Z-phase mapping wrong");
      chk_fixed_minus: assert property (
        s_fall_minus |=> o_start_minus[a] ##1 !o_start_minus[a])
        else $error("fixed minus start pulse wrong");
      chk_cont_plus: assert property (
        (mode == ext_cont && !emg_act) |=> (o_run_plus[a] == !$past(s_expp[a])))
        else $error("continuous plus run not following start input");
      chk_mpg_phase_b: assert property (
        (mode == ext_mpg) |=> (o_mpg_b[a] == $past(s_expm[a])) && !o_start_minus[a])
        else $error("pulse generator phase B mapping wrong");
      chk_stop_decel: assert property (
        (!i_home_search[a] && (|stop_act[4*a+:4]) && !i_stop_sudden[a] && !emg_act)
        |=> o_decel_stop[a])
        else $error("stop input did not request decelerating stop");
      chk_status_b: assert property (
        (up_q == field_lat) |-> (o_input_status_b[4*a+3] == $past(i_servo_alarm[a], 3)))
        else $error("alarm level not in status word");
    end
  endgenerate

  // General outputs written directly, no axis selection
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_general_out <= gen_out_rst;
    end else if (i_out_wr) begin
      o_general_out <= i_out_data;
    end
  end

  chk_gen_reset: assert property (disable iff (1'b0)
    (i_sys_rst ##1 !i_out_wr[*2]) |-> o_general_out == gen_out_rst)
    else $error("general outputs not low after reset");
  chk_gen_write: assert property (i_out_wr |=> o_general_out == $past(i_out_data))
    else $error("general outputs not updated by write");
  chk_gen_hold: assert property (!i_out_wr |=> $stable(o_general_out))
    else $error("general outputs changed without write");

  // Drive status and in-position wait
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_axis_driving_flag <= 4'h0;
      o_drive_active_out <= 4'h0;
    end else begin
      o_axis_driving_flag <= drv_d;
      o_drive_active_out <= drv_d;
    end
  end

  // Error status bits
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_alarm_flag <= 4'h0;
      o_hw_plus_limit_flag <= 4'h0;
      o_hw_minus_limit_flag <= 4'h0;
      o_emergency_flag <= 4'h0;
    end else begin
      o_alarm_flag <= alarm_act;
      o_hw_plus_limit_flag <= i_lmt_en & lmtp_act;
      o_hw_minus_limit_flag <= i_lmt_en & lmtm_act;
      o_emergency_flag <= {4{emg_act}};
    end
  end

  // Stop requests to the pulse generators
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_decel_stop <= 4'h0;
      o_sudden_stop <= 4'h0;
      o_emergency_halt <= 1'b0;
    end else begin
      o_decel_stop <= dec_d;
      o_sudden_stop <= sud_d;
      o_emergency_halt <= emg_act;
    end
  end

  chk_emg_all: assert property (
    emg_act |=> o_emergency_halt && (o_sudden_stop == 4'hf) && (o_run_plus == 4'h0)
                && (o_emergency_flag == 4'hf))
    else $error("emergency did not halt every axis");
  chk_emg_pin: assert property (
    (up_q == field_lat) |-> (o_emergency_halt == !$past(i_emergency_stop_n, 3)))
    else $error("emergency not active low");

  // Input level status words
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_input_status_a <= fld_rst[fld_stop+:16];
      o_input_status_b <= 16'hffff;
    end else begin
      o_input_status_a <= s_stop;
      o_input_status_b <= stat_b_d;
    end
  end

  chk_status_sync: assert property (
    (up_q == field_lat) |-> (o_input_status_a == $past(i_stop_inputs, 3)))
    else $error("status word not synchronised pin levels");

  // External start and pulse generator paths
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_start_plus <= 4'h0;
      o_start_minus <= 4'h0;
      o_run_plus <= 4'h0;
      o_run_minus <= 4'h0;
      o_mpg_a <= 4'h0;
      o_mpg_b <= 4'h0;
    end else begin
      o_start_plus <= stp_d;
      o_start_minus <= stm_d;
      o_run_plus <= rnp_d;
      o_run_minus <= rnm_d;
      o_mpg_a <= mpa_d;
      o_mpg_b <= mpb_d;
    end
  end

  // Home search sensor taps from stop inputs 0 to 2
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_home_near <= 4'h0;
      o_home_signal <= 4'h0;
      o_home_zphase <= 4'h0;
    end else begin
      for (int k = 0; k < num_axes; k++) begin
        o_home_near[k] <= i_home_search[k] & stop_act[stop_per_axis*k];
        o_home_signal[k] <= i_home_search[k] & stop_act[stop_per_axis*k+1];
        o_home_zphase[k] <= i_home_search[k] & stop_act[stop_per_axis*k+2];
      end
    end
  end

endmodule : axis_io_signal_handling

/* File: testbench/field_model.sv */
// Field side model: sensors, switches and servo drivers behind the pins
`timescale 1ns/1ps
module field_model
  import axis_io_pkg::*;
(
  input wire logic i_clk,
  input wire logic [fld_w-1:0] i_req,
  output logic [fld_w-1:0] o_pins
);
  logic [1:0] hold_q = 2'h0;
  initial o_pins = fld_rst;
  // Each new level is held at least three clocks before the next change
  always @(negedge i_clk) begin
    if (hold_q != 2'h0) begin
      hold_q <= hold_q - 2'h1;
    end else if (i_req !== o_pins) begin
      o_pins <= i_req;
      hold_q <= 2'(min_pulse_clk);
    end
  end
endmodule : field_model

/* File: testbench/tb.sv */
// Self-checking bench for the axis signal handling block
`timescale 1ns/1ps
module tb;
  import axis_io_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wr = 1'b0;
  logic [15:0] wdata = 16'h0000;
  logic [3:0] ipe = 4'h0, ipl = 4'h0, ale = 4'h0, alv = 4'h0, lme = 4'h0, lml = 4'h0;
  logic [3:0] lms = 4'h0, sts = 4'h0, busy = 4'h0, dir = 4'h0, home = 4'h0;
  logic [15:0] ste = 16'h0000, stl = 16'h0000, mode = 16'h1111;
  logic [fld_w-1:0] req = fld_rst;
  logic [fld_w-1:0] pin;
  logic [15:0] gout, isa, isb;
  logic [3:0] drv, dao, alf, hpf, hmf, emf, dec, sud, stp, stm, rnp, rnm, ma, mb, hn, hs, hz;
  logic halt;
  int err_count = 0;
  int checks_done = 0;
  int n;
  field_model fm (.i_clk(clk), .i_req(req), .o_pins(pin));
  axis_io_signal_handling uut (.i_clk(clk), .i_sys_rst(rst), .i_out_data(wdata),
    .i_out_wr(wr), .i_inpos_en(ipe), .i_inpos_lvl(ipl), .i_alarm_en(ale),
    .i_alarm_lvl(alv), .i_lmt_en(lme), .i_lmt_lvl(lml), .i_lmt_sudden(lms),
    .i_stop_en(ste), .i_stop_lvl(stl), .i_stop_sudden(sts), .i_ext_mode(mode),
    .i_pulse_busy(busy), .i_pulse_dir(dir), .i_home_search(home),
    .i_in_position(pin[fld_inpos +: 4]), .i_servo_alarm(pin[fld_alarm +: 4]),
    .i_plus_limit(pin[fld_lmtp +: 4]), .i_minus_limit(pin[fld_lmtm +: 4]),
    .i_stop_inputs(pin[fld_stop +: 16]), .i_ext_plus_start(pin[fld_expp +: 4]),
    .i_ext_minus_start(pin[fld_expm +: 4]), .i_emergency_stop_n(pin[fld_emg]),
    .o_general_out(gout), .o_axis_driving_flag(drv), .o_drive_active_out(dao),
    .o_alarm_flag(alf), .o_hw_plus_limit_flag(hpf), .o_hw_minus_limit_flag(hmf),
    .o_emergency_flag(emf), .o_decel_stop(dec), .o_sudden_stop(sud),
    .o_emergency_halt(halt), .o_input_status_a(isa), .o_input_status_b(isb),
    .o_start_plus(stp), .o_start_minus(stm), .o_run_plus(rnp), .o_run_minus(rnm),
    .o_mpg_a(ma), .o_mpg_b(mb), .o_home_near(hn), .o_home_signal(hs),
    .o_home_zphase(hz));
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic tick(input int c);
    repeat (c) @(negedge clk);
  endtask : tick
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %0t saw %h wanted %h", $time, seen, exp);
    end
  endtask : chk
  task automatic give_verdict;
    if (err_count == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : give_verdict
  initial begin
    tick(6);
    rst <= 1'b0;
    tick(1);
    chk(gout, 16'h0000);
    chk(isa & isb, 16'hffff);
    wr <= 1'b1;
    wdata <= 16'ha5c3;
    tick(1);
    chk(gout, 16'ha5c3);
    wdata <= 16'h3c5a;
    tick(1);
    wr <= 1'b0;
    tick(4);
    chk(gout, 16'h3c5a);
    // Plus limit, active low, on axis 0 during plus drive
    busy <= 4'h1;
    dir <= 4'h1;
    lme <= 4'h1;
    req[fld_lmtp] <= 1'b0;
    tick(8);
    chk(16'({hpf, dec, sud}), 16'h110);
    chk(isb, 16'hfffe);
    lms <= 4'h1;
    tick(2);
    chk(16'({dec, sud}), 16'h01);
    lme <= 4'h0;
    tick(2);
    chk(16'(hpf), 16'h0);
    // Minus limit on axis 1, active high, idle-high pin is active
    req[fld_lmtp] <= 1'b1;
    req[fld_lmtp + 1] <= 1'b0;
    lml <= 4'h2;
    lme <= 4'h2;
    lms <= 4'h2;
    busy <= 4'h2;
    dir <= 4'h2;
    tick(8);
    chk(16'({hmf, hpf, sud}), 16'h200);
    dir <= 4'h0;
    tick(2);
    chk(16'(sud), 16'h2);
    req[fld_lmtp + 1] <= 1'b1;
    lml <= 4'h0;
    lme <= 4'h0;
    busy <= 4'h0;
    // Alarm on axis 2
    ale <= 4'h4;
    req[fld_alarm + 2] <= 1'b0;
    tick(8);
    chk(16'(alf), 16'h4);
    chk(isb, 16'hf7ff);
    ale <= 4'h0;
    tick(2);
    chk(16'(alf), 16'h0);
    req[fld_alarm + 2] <= 1'b1;
    // Stop inputs 0..2 of axis 1, then home search reuse
    ste <= 16'h0070;
    sts <= 4'h2;
    req[fld_stop + 4 +: 3] <= 3'h0;
    tick(8);
    chk(16'({dec, sud}), 16'h02);
    chk(isa, 16'hff8f);
    sts <= 4'h0;
    tick(2);
    chk(16'({dec, sud}), 16'h20);
    home <= 4'h2;
    tick(2);
    chk(16'({sud, hn, hs, hz}), 16'h0222);
    home <= 4'h0;
    ste <= 16'h0000;
    req[fld_stop + 4 +: 3] <= 3'h7;
    // Fixed start on axis 3, one pulse each direction
    mode <= 16'h2111;
    for (int d = 0; d < 2; d++) begin
      req[(d == 1 ? fld_expm : fld_expp) + 3] <= 1'b0;
      n = 0;
      repeat (10) begin
        tick(1);
        n += (d == 1) ? int'(stm[3]) : int'(stp[3]);
      end
      chk(16'(n), 16'h1);
      req[(d == 1 ? fld_expm : fld_expp) + 3] <= 1'b1;
      tick(8);
    end
    mode <= 16'h4111;
    req[fld_expp + 3] <= 1'b0;
    tick(8);
    chk(16'({rnp, rnm}), 16'h80);
    req[fld_expp + 3] <= 1'b1;
    req[fld_expm + 3] <= 1'b0;
    tick(8);
    chk(16'({rnp, rnm}), 16'h08);
    mode <= 16'h8111;
    tick(8);
    chk(16'({ma, mb}), 16'h80);
    mode <= 16'h1111;
    req[fld_expm + 3] <= 1'b1;
    tick(2);
    chk(16'({ma, mb}), 16'h00);
    // In-position wait on axis 0, active low
    ipe <= 4'h1;
    busy <= 4'h1;
    tick(2);
    busy <= 4'h0;
    tick(6);
    chk(16'({drv, dao}), 16'h11);
    req[fld_inpos] <= 1'b0;
    tick(8);
    chk(16'({drv, dao}), 16'h00);
    // Emergency stop
    req[fld_emg] <= 1'b0;
    tick(8);
    chk(16'({halt, emf, sud}), 16'h1ff);
    req[fld_emg] <= 1'b1;
    tick(8);
    chk(16'({halt, emf}), 16'h00);
    give_verdict();
  end
endmodule : tb
